// ---- rtl/pdpc_regs.svh ----
// Timing counts and reset values for the source power-path controller.
// Assumes a 100 MHz reference clock; included by its bare name.
`ifndef PDPC_REGS_SVH
`define PDPC_REGS_SVH

// =============================================================
// Clock rate
`define PDPC_CLK_HZ 100000000

// =============================================================
// Dead-battery enable pulse period and width
`define PDPC_DB_PERIOD_S 10
`define PDPC_DB_PERIOD_CYC (`PDPC_DB_PERIOD_S * `PDPC_CLK_HZ)
`define PDPC_DB_WIDTH_MS 10
`define PDPC_DB_WIDTH_CYC (`PDPC_DB_WIDTH_MS * (`PDPC_CLK_HZ / 1000))

// =============================================================
// Supply shut-down time during fault recovery
`define PDPC_FAULT_OFF_MS 100
`define PDPC_FAULT_OFF_CYC (`PDPC_FAULT_OFF_MS * (`PDPC_CLK_HZ / 1000))

// =============================================================
// Synchroniser reset value: bit 0 plug detect (idle high), bit 1 VBUS, bit 2 fault
`define PDPC_SYNC_RST 3'h1
`define PDPC_SYNC_PLUG 0
`define PDPC_SYNC_VBUS 1
`define PDPC_SYNC_FAULT 2

`endif

// ---- rtl/pdpc_pkg.sv ----
// Types shared by the source power-path controller files.
// Assumes nothing of its surroundings.
package pdpc_pkg;

  // =============================================================
  // Source supervision states
  typedef enum logic [2:0] {
    ST_STARTUP,
    ST_NEGOTIATE,
    ST_CONTRACT,
    ST_FAULT_OFF
  } pdpc_state_t;

  // Counter step used by every timer of the block.
  function automatic logic [31:0] pdpc_inc(input logic [31:0] val);
    pdpc_inc = val + 32'h00000001;
  endfunction : pdpc_inc

endpackage : pdpc_pkg

// ---- rtl/pdpc_sync.sv ----
// Two-flop synchroniser for the three asynchronous pin inputs.
// Assumes the pins are quasi-static compared with the reference clock.
`timescale 1ns/10ps
`include "pdpc_regs.svh"

module pdpc_sync (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sysRstN,
  // Pins and their synchronised copies
  input wire logic [2:0] pinAsync,
  output logic [2:0] pinSync
);

  logic [2:0] meta_r;

  // =============================================================
  // Only the second stage is read; the first may be metastable.
  always_ff @(posedge ref_clk) begin
    if (!sysRstN) begin
      meta_r <= `PDPC_SYNC_RST;
      pinSync <= `PDPC_SYNC_RST;
    end else begin
      meta_r <= pinAsync;
      pinSync <= meta_r;
    end
  end

endmodule : pdpc_sync

// ---- rtl/pdpc_top.sv ----
// Power-path supervisor of a USB PD source port: plug qualification,
// dead-battery pulsing, bulk charge gating and fault recovery.
// Assumes the policy logic on the same clock reports role and negotiation result.
`timescale 1ns/10ps
`include "pdpc_regs.svh"

module pdpc_top #(
  parameter logic [31:0] DB_PERIOD_CYC = `PDPC_DB_PERIOD_CYC,
  parameter logic [31:0] DB_WIDTH_CYC = `PDPC_DB_WIDTH_CYC,
  parameter logic [31:0] FAULT_OFF_CYC = `PDPC_FAULT_OFF_CYC
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sysRstN,
  // Pins from the receptacle and supply
  input wire logic insertDetN,
  input wire logic vbusPresent,
  input wire logic sysFaultIn,
  // Policy logic on the same clock
  input wire logic roleConsumer,
  input wire logic negDone,
  input wire logic negFail,
  // Supply control pins
  output logic vbusEn_r,
  output logic deadbattSupplyEn_r,
  output logic bulkChargeEn_r,
  // Towards the policy logic
  output logic negStart_r,
  output logic faultActive_r
);

  logic [2:0] pinSync;
  logic plugOut;
  logic vbusSeen;
  logic faultSeen;
  pdpc_pkg::pdpc_state_t state_r;
  pdpc_pkg::pdpc_state_t state_nxt;
  logic [31:0] offCnt_r;
  logic [31:0] dbCnt_r;
  logic offDone;
  logic srcOn;

  // =============================================================
  // Pin synchronisation
  pdpc_sync u_sync (
    .ref_clk(ref_clk),
    .sysRstN(sysRstN),
    .pinAsync({sysFaultIn, vbusPresent, insertDetN}),
    .pinSync(pinSync)
  );

  // Idle-high plug detect, so a floating or unplugged socket reads as out.
  assign plugOut = pinSync[`PDPC_SYNC_PLUG];
  assign vbusSeen = pinSync[`PDPC_SYNC_VBUS];
  assign faultSeen = pinSync[`PDPC_SYNC_FAULT];
  assign offDone = (offCnt_r == FAULT_OFF_CYC - 32'h00000001);

  // =============================================================
  // Next-state logic. Unplug beats everything so the socket goes cold at once.
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      pdpc_pkg::ST_STARTUP: begin
        if (!plugOut && !roleConsumer) begin
          state_nxt = pdpc_pkg::ST_NEGOTIATE;
        end
      end
      pdpc_pkg::ST_NEGOTIATE: begin
        if (plugOut || roleConsumer) begin
          state_nxt = pdpc_pkg::ST_STARTUP;
        end else if (faultSeen || negFail) begin
          state_nxt = pdpc_pkg::ST_FAULT_OFF;
        end else if (negDone) begin
          state_nxt = pdpc_pkg::ST_CONTRACT;
        end
      end
      pdpc_pkg::ST_CONTRACT: begin
        if (plugOut || roleConsumer) begin
          state_nxt = pdpc_pkg::ST_STARTUP;
        end else if (faultSeen) begin
          state_nxt = pdpc_pkg::ST_FAULT_OFF;
        end
      end
      pdpc_pkg::ST_FAULT_OFF: begin
        if (plugOut || roleConsumer) begin
          state_nxt = pdpc_pkg::ST_STARTUP;
        end else if (offDone) begin
          state_nxt = pdpc_pkg::ST_NEGOTIATE;
        end
      end
      default: begin
        state_nxt = pdpc_pkg::ST_STARTUP;
      end
    endcase
  end

  assign srcOn = (state_nxt == pdpc_pkg::ST_NEGOTIATE) || (state_nxt == pdpc_pkg::ST_CONTRACT);

  // State register; reset returns the port to a cold socket.
  always_ff @(posedge ref_clk) begin
    if (!sysRstN) begin
      state_r <= pdpc_pkg::ST_STARTUP;
    end else begin
      state_r <= state_nxt;
    end
  end

  // =============================================================
  // Shut-down timer, running only while the supply is held off after a fault.
  always_ff @(posedge ref_clk) begin
    if (!sysRstN || state_r != pdpc_pkg::ST_FAULT_OFF || offDone) begin
      offCnt_r <= 32'h00000000;
    end else begin
      offCnt_r <= pdpc_pkg::pdpc_inc(offCnt_r);
    end
  end

  // =============================================================
  // Supply, bulk charge and negotiation outputs, all from the next state.
  always_ff @(posedge ref_clk) begin
    if (!sysRstN) begin
      vbusEn_r <= 1'b0;
      bulkChargeEn_r <= 1'b0;
      negStart_r <= 1'b0;
      faultActive_r <= 1'b0;
    end else begin
      vbusEn_r <= srcOn && !plugOut;
      bulkChargeEn_r <= srcOn && !plugOut && !roleConsumer;
      negStart_r <= (state_nxt == pdpc_pkg::ST_NEGOTIATE) &&
        (state_r != pdpc_pkg::ST_NEGOTIATE);
      faultActive_r <= (state_nxt == pdpc_pkg::ST_FAULT_OFF);
    end
  end

  // =============================================================
  // Dead-battery timer. Pulse sits at the start of each period, so the first
  // one goes out right after VBUS vanishes; any VBUS sighting restarts it.
  always_ff @(posedge ref_clk) begin
    if (!sysRstN || vbusSeen) begin
      dbCnt_r <= 32'h00000000;
    end else if (dbCnt_r == DB_PERIOD_CYC - 32'h00000001) begin
      dbCnt_r <= 32'h00000000;
    end else begin
      dbCnt_r <= pdpc_pkg::pdpc_inc(dbCnt_r);
    end
  end

  // A back-powered VBUS ends its own pulse; that is intended, not a glitch.
  always_ff @(posedge ref_clk) begin
    if (!sysRstN) begin
      deadbattSupplyEn_r <= 1'b0;
    end else begin
      deadbattSupplyEn_r <= !vbusSeen && (dbCnt_r < DB_WIDTH_CYC);
    end
  end

  // =============================================================
  // Assertions
  plug_startup_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    (state_r == pdpc_pkg::ST_STARTUP) && !plugOut && !roleConsumer |=> negStart_r && vbusEn_r)
    else $error("Qualified plug did not leave startup.");

  cold_socket_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    plugOut |=> !vbusEn_r && !bulkChargeEn_r)
    else $error("VBUS driven while plug detect high.");

  db_pulse_start_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    !vbusSeen && (dbCnt_r == 32'h00000000) |=> deadbattSupplyEn_r)
    else $error("Dead-battery pulse missing at period start.");

  db_period_wrap_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    !vbusSeen && (dbCnt_r == DB_PERIOD_CYC - 32'h00000001) |=> (dbCnt_r == 32'h00000000))
    else $error("Dead-battery period did not wrap.");

  db_stop_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    vbusSeen |=> !deadbattSupplyEn_r && (dbCnt_r == 32'h00000000))
    else $error("Dead-battery pulse with VBUS present.");

  bulk_consumer_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    roleConsumer |=> !bulkChargeEn_r)
    else $error("Bulk charge on in consumer role.");

  bulk_follow_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    vbusEn_r && !$past(roleConsumer) |-> bulkChargeEn_r)
    else $error("Bulk charge off while sourcing as provider.");

  // Unplug and consumer role outrank a fault, so those cycles go to startup instead.
  fault_shut_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    faultSeen && !plugOut && !roleConsumer &&
      ((state_r == pdpc_pkg::ST_NEGOTIATE) || (state_r == pdpc_pkg::ST_CONTRACT)) |=>
      !vbusEn_r && faultActive_r)
    else $error("Fault did not shut the supply.");

  fault_retry_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    (state_r == pdpc_pkg::ST_FAULT_OFF) && offDone && !plugOut && !roleConsumer |=>
      negStart_r && vbusEn_r ##1 !negStart_r)
    else $error("Supply not re-enabled after shut-down time.");

  neg_pulse_a: assert property (@(posedge ref_clk) disable iff (!sysRstN)
    negStart_r |=> !negStart_r)
    else $error("Negotiation start held for more than one cycle.");

  reset_hold_a: assert property (@(posedge ref_clk)
    !sysRstN |=> (state_r == pdpc_pkg::ST_STARTUP) && !vbusEn_r && !deadbattSupplyEn_r)
    else $error("Outputs active under reset.");

  contract_c: cover property (@(posedge ref_clk) disable iff (!sysRstN)
    (state_r == pdpc_pkg::ST_NEGOTIATE) ##1 (state_r == pdpc_pkg::ST_CONTRACT));
  recovery_c: cover property (@(posedge ref_clk) disable iff (!sysRstN)
    (state_r == pdpc_pkg::ST_FAULT_OFF) ##1 (state_r == pdpc_pkg::ST_NEGOTIATE));
  negfail_c: cover property (@(posedge ref_clk) disable iff (!sysRstN)
    (state_r == pdpc_pkg::ST_NEGOTIATE) && negFail ##1 faultActive_r);
  db_pulse_c: cover property (@(posedge ref_clk) disable iff (!sysRstN)
    $rose(deadbattSupplyEn_r));

endmodule : pdpc_top

// ---- bench/pdpc_far_side.sv ----
// Far-side model: receptacle detect pin, DC-DC supply and fault comparator.
// Assumes the bench changes its commands just after a rising clock edge.
`timescale 1ns/10ps

module pdpc_far_side (
  // Clock
  input wire logic ref_clk,
  // Commands from the bench
  input wire logic plugged,
  input wire logic extVbus,
  input wire logic faultCmd,
  // Supply enable from the block
  input wire logic vbusEn,
  // Pins towards the block
  output logic insertDetN,
  output logic vbusPresent,
  output logic sysFaultIn
);
  // =============================================================
  // Supply model
  logic [1:0] ramp_r = 2'h0;

  // The supply takes two cycles to ramp, so VBUS never follows the enable at once.
  always_ff @(posedge ref_clk) begin
    ramp_r <= {ramp_r[0], vbusEn};
  end

  // The detect pin has a pull-up, so it reads high while no plug is seated.
  assign insertDetN = !plugged;
  assign vbusPresent = ramp_r[1] | extVbus;
  assign sysFaultIn = faultCmd;
endmodule : pdpc_far_side

// ---- bench/pdpc_top_tb_top.sv ----
// Self-checking bench for the source power-path supervisor.
// Assumes short timer parameters so that every count is seen in a short run.
`timescale 1ns/10ps

module pdpc_top_tb_top;
  // =============================================================
  // Signals and counters
  logic ref_clk = 1'b0;
  logic sysRstN = 1'b0;
  logic plugged = 1'b0;
  logic extVbus = 1'b0;
  logic faultCmd = 1'b0;
  logic roleConsumer = 1'b0;
  logic negDone = 1'b0;
  logic negFail = 1'b0;
  logic insertDetN, vbusPresent, sysFaultIn;
  logic vbusEn_r, deadbattSupplyEn_r, bulkChargeEn_r, negStart_r, faultActive_r;
  int fail_count = 0;
  int n_checks = 0;
  int cyc;

  // Clock at 100 MHz.
  always #5 ref_clk = !ref_clk;

  // =============================================================
  // Block and far side
  pdpc_top #(.DB_PERIOD_CYC(32'hC8), .DB_WIDTH_CYC(32'h5), .FAULT_OFF_CYC(32'hA)) dut (
    .ref_clk(ref_clk), .sysRstN(sysRstN), .insertDetN(insertDetN),
    .vbusPresent(vbusPresent), .sysFaultIn(sysFaultIn), .roleConsumer(roleConsumer),
    .negDone(negDone), .negFail(negFail), .vbusEn_r(vbusEn_r),
    .deadbattSupplyEn_r(deadbattSupplyEn_r), .bulkChargeEn_r(bulkChargeEn_r),
    .negStart_r(negStart_r), .faultActive_r(faultActive_r));
  pdpc_far_side far (
    .ref_clk(ref_clk), .plugged(plugged), .extVbus(extVbus), .faultCmd(faultCmd),
    .vbusEn(vbusEn_r), .insertDetN(insertDetN), .vbusPresent(vbusPresent),
    .sysFaultIn(sysFaultIn));

  // =============================================================
  // Shared tasks
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      fail_count++;
    end
  endtask : chk

  // Waits a bounded number of cycles for vbusEn_r (0) or faultActive_r (1).
  task automatic wait_out(input int which, input int lim, output int n);
    n = 0;
    while ((which == 0 ? vbusEn_r : faultActive_r) !== 1'b1 && n < lim) begin
      step(1);
      n++;
    end
    chk("wait ended", 1'b1, n < lim);
  endtask : wait_out

  // Counts the cycles of dead-battery enable over a fixed span.
  task automatic count_db(input int span, output int n);
    n = 0;
    repeat (span) begin
      step(1);
      n += (deadbattSupplyEn_r === 1'b1);
    end
  endtask : count_db

  // Checks that every output is low, as it must be under reset.
  task automatic all_low();
    chk("outputs", 5'h0, {vbusEn_r, deadbattSupplyEn_r, bulkChargeEn_r, negStart_r,
        faultActive_r});
  endtask : all_low

  // =============================================================
  // Scenarios
  task automatic t_deadbatt();
    count_db(300, cyc);
    chk("db high cycles", 32'hA, cyc);
  endtask : t_deadbatt

  // A plug in consumer role, and no plug at all, must both leave VBUS off.
  task automatic t_refused();
    step(10);
    chk("vbus no plug", 1'b0, vbusEn_r);
    roleConsumer = 1'b1;
    plugged = 1'b1;
    step(10);
    chk("vbus consumer", 1'b0, vbusEn_r);
    chk("bulk consumer", 1'b0, bulkChargeEn_r);
    // The detect pin must read out through the synchroniser before the role
    // clears, or the stale low detect would be qualified as a fresh insertion.
    plugged = 1'b0;
    step(5);
    roleConsumer = 1'b0;
    step(5);
  endtask : t_refused

  task automatic t_plug();
    plugged = 1'b1;
    wait_out(0, 8, cyc);
    chk("plug latency", 32'h3, cyc);
    chk("bulk on", 1'b1, bulkChargeEn_r);
    chk("neg start", 1'b1, negStart_r);
    step(1);
    chk("neg start end", 1'b0, negStart_r);
    negDone = 1'b1;
    step(1);
    negDone = 1'b0;
    step(5);
    count_db(300, cyc);
    chk("db with vbus", 32'h0, cyc);
  endtask : t_plug

  // The fault is held through one recovery, so the supply must shut a second time.
  task automatic t_fault();
    faultCmd = 1'b1;
    wait_out(1, 8, cyc);
    chk("fault latency", 32'h3, cyc);
    chk("vbus off", 1'b0, vbusEn_r);
    chk("bulk off", 1'b0, bulkChargeEn_r);
    wait_out(0, 20, cyc);
    chk("off time ok", 1'b1, cyc >= 10 && cyc <= 12);
    chk("renegotiate", 1'b1, negStart_r);
    wait_out(1, 8, cyc);
    faultCmd = 1'b0;
    wait_out(0, 20, cyc);
    // A failed negotiation must cycle the supply just as a fault does.
    negFail = 1'b1;
    step(1);
    negFail = 1'b0;
    chk("negfail shut", 1'b1, faultActive_r);
    chk("negfail vbus", 1'b0, vbusEn_r);
    wait_out(0, 20, cyc);
    chk("negfail retry", 32'hA, cyc);
    negDone = 1'b1;
    step(1);
    negDone = 1'b0;
    step(20);
    chk("vbus kept", 1'b1, vbusEn_r);
    chk("fault clear", 1'b0, faultActive_r);
  endtask : t_fault

  // A role change to consumer in mid-contract drops bulk charging and VBUS.
  task automatic t_role();
    roleConsumer = 1'b1;
    step(2);
    chk("bulk role", 1'b0, bulkChargeEn_r);
    chk("vbus role", 1'b0, vbusEn_r);
    // With VBUS gone the dead-battery pulses must come back, two periods' worth.
    count_db(210, cyc);
    chk("db resumes", 32'hA, cyc);
    roleConsumer = 1'b0;
  endtask : t_role

  task automatic t_midreset();
    step(3);
    sysRstN = 1'b0;
    step(2);
    all_low();
    sysRstN = 1'b1;
    // The plug stays in, but the synchroniser reads it out for two edges.
    step(2);
    chk("vbus after reset", 1'b0, vbusEn_r);
    chk("neg after reset", 1'b0, negStart_r);
    step(1);
    chk("vbus replug", 1'b1, vbusEn_r);
  endtask : t_midreset

  // =============================================================
  // Verdict, the one place where the run ends
  task automatic finish_test();
    if (fail_count == 0 && n_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : finish_test

  // Main sequence.
  initial begin
    step(16);
    all_low();
    sysRstN = 1'b1;
    t_deadbatt();
    t_refused();
    t_plug();
    t_fault();
    t_role();
    t_midreset();
    finish_test();
  end

  // The whole run needs about 930 cycles, so 100 us marks a hang.
  initial begin
    #100000;
    fail_count++;
    finish_test();
  end
endmodule : pdpc_top_tb_top
